// ---- logic/qcef_event_flags.sv ----
// Event and interrupt flag logic of a quadrature position counter.
// Assumes the counter core runs on clk and feeds count values, step
// pulses and index events directly, with no synchronisation needed.
//
// Implementation choices: the register offsets and strobed register access.
`timescale 1ns/10ps
`default_nettype none

// Overview of operation
// [R1] Pos-or-rev flag with enable drives interrupt.
// [R2] Position equals compare sets position flag.
// [R3] Write 0 clears flag, 1 keeps.
// [R4] Read-modify-write reads every flag as 1.
// [R5] Enabling position mode on match sets flag.
// [R6] Halted count write matching compare sets flag.
// [R7] Compare write matching count sets flag.
// [R8] Position flag with enable drives interrupt.
// [R9] Top two control bits read zero.
// [R10] Both matches together set combined flag.
// [R11] Position enable with both matches sets combined.
// [R12] Count or compare write completes combined match.
// [R13] Revolution compare write completes combined match.
// [R14] Revolution mode enable with matches sets combined.
// [R15] Combined flag with enable drives interrupt.
// [R16] Overflow direction captured at each flow.
// [R17] Last direction follows latest count step.
// [R18] Early index resets position unless revolution mode 2, blocks revolution.
// [R19] Direction reversal sets inversion flag.
// [R20] First reversal after enable is ignored.
// [R21] Inversion flag with enable drives interrupt.
// [R22] One level interrupt from all flag pairs.
module qcef_event_flags
  import qcef_pkg::*;
#(
  parameter int CNT_W = 16
) (
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic [7:0]        reg_addr,
  input  wire logic [31:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  input  wire logic              reg_rmw,
  output logic      [31:0]       reg_rdata,
  input  wire logic [CNT_W-1:0]  pos_count,
  input  wire logic [CNT_W-1:0]  rev_count,
  input  wire logic              step_pulse,
  input  wire logic              step_down,
  input  wire logic              flow_pulse,
  input  wire logic              phase_edge,
  input  wire logic              index_edge,
  output logic      [1:0]        position_mode,
  output logic      [1:0]        revolution_count_mode,
  output logic                   position_halt_bit,
  output logic                   revolution_compare_select,
  output logic                   pos_load_valid,
  output logic      [CNT_W-1:0]  pos_load_data,
  output logic                   pos_reset_req,
  output logic                   rev_count_inhibit,
  output logic                   irq
);

  // Control fields written by software.
  logic [1:0]       pmode_r;     // Position count mode.
  logic [1:0]       rmode_r;     // Revolution count mode.
  logic             halt_r;      // Position halt bit.
  logic             revolution_compare_select_r;      // Revolution compare select.
  logic [CNT_W-1:0] pos_cmp_r;   // Position compare register.
  logic [CNT_W-1:0] rev_cmp_r;   // Revolution compare register.
  // Interrupt enables.
  logic             pos_ie_r;
  logic             por_ie_r;
  logic             cmb_ie_r;
  logic             inv_ie_r;
  // Sticky request flags.
  logic             pos_f_r;
  logic             por_f_r;
  logic             cmb_f_r;
  logic             inv_f_r;
  // Direction state.
  logic             ovf_dir_r;   // Direction at last flow.
  logic             last_dir_r;  // Direction of last step.
  logic             dir_known_r; // A step was seen since enable.
  logic             no_phase_r;  // No phase edge since enable.
  // Previous values used to detect changes.
  logic [1:0]       pmode_prev_r;
  logic [1:0]       rmode_prev_r;
  logic             revolution_compare_select_prev_r;
  logic [CNT_W-1:0] pos_prev_r;
  logic [CNT_W-1:0] rev_prev_r;
  // Output registers of the bus and pulses.
  logic [31:0]      rdata_r;
  logic             load_v_r;
  logic [CNT_W-1:0] load_d_r;
  logic             preset_r;
  logic             rinh_r;

  // Write decode strobes.
  logic wr_irq;
  logic wr_ctrl;
  logic wr_cnt;
  logic wr_pcmp;
  logic wr_rcmp;
  assign wr_irq  = reg_wr && (reg_addr == QCEF_IRQ_CTRL_OFS);
  assign wr_ctrl = reg_wr && (reg_addr == QCEF_CNT_CTRL_OFS);
  assign wr_cnt  = reg_wr && (reg_addr == QCEF_POS_COUNT_OFS);
  assign wr_pcmp = reg_wr && (reg_addr == QCEF_POS_CMP_OFS);
  assign wr_rcmp = reg_wr && (reg_addr == QCEF_REV_CMP_OFS);

  // Data written for the compare and count registers.
  logic [CNT_W-1:0] wval;
  assign wval = reg_wdata[CNT_W-1:0];

  // Mode conditions.
  logic pos_en;
  logic rev_en;
  logic pos_enter;
  logic rev_enter;
  assign pos_en    = (pmode_r != QCEF_MODE_OFF);
  assign rev_en    = (rmode_r != QCEF_MODE_OFF);
  assign pos_enter = pos_en && (pmode_prev_r == QCEF_MODE_OFF);
  assign rev_enter = rev_en && (rmode_prev_r == QCEF_MODE_OFF);

  // Live compare matches against the counter core.
  logic pos_match;
  logic rev_match;
  logic por_match;
  logic pos_chg;
  logic rev_chg;
  assign pos_match = (pos_count == pos_cmp_r);
  assign rev_match = (rev_count == rev_cmp_r);
  assign por_match = revolution_compare_select_r ? (rev_count == rev_cmp_r)
                            : (pos_count == rev_cmp_r);
  assign pos_chg   = (pos_count != pos_prev_r);
  assign rev_chg   = (rev_count != rev_prev_r);

  // Position flag set terms. A counter change into match is the normal
  // path; the write terms compare the written value directly so the
  // flag rises without waiting for the counter to reload.
  logic pos_set;
  logic pos_wr_hit;
  // [R6] Halted count write.
  assign pos_wr_hit = (wr_cnt && halt_r && pos_en && (wval == pos_cmp_r))
  // [R7] Compare register write.
                   || (wr_pcmp && pos_en && (wval == pos_count));
  // [R2] Counter reaches compare, [R5] mode enable on match.
  assign pos_set = (pos_en && pos_match && (pos_chg || pos_enter))
                || pos_wr_hit;

  // Combined flag set terms.
  logic cmb_set;
  // [R10] Both counters match together, select bit ignored.
  // [R11] Position enable, [R14] revolution enable with both matches.
  // [R12] Count or compare write, [R13] revolution compare write.
  assign cmb_set =
      (pos_en && rev_en && pos_match && rev_match
        && (pos_chg || rev_chg || pos_enter || rev_enter))
   || (pos_wr_hit && rev_en && rev_match)
   || (wr_rcmp && rev_en && pos_en && pos_match && (wval == rev_count));

  // Position-or-revolution flag set: counter change, mode entry,
  // compare write or a change of the select bit.
  logic por_set;
  assign por_set =
      (pos_en && por_match
        && ((revolution_compare_select_r ? rev_chg : pos_chg) || pos_enter || rev_enter
            || (revolution_compare_select_r != revolution_compare_select_prev_r)))
   || (wr_rcmp && pos_en
        && (wval == (revolution_compare_select_r ? rev_count : pos_count)));

  // [R19] Direction reversal; [R20] needs a known previous direction.
  logic inv_set;
  assign inv_set = step_pulse && pos_en && dir_known_r
                && (step_down != last_dir_r);

  // Control register, written by software only.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pmode_r <= QCEF_MODE_RST;
      rmode_r <= QCEF_MODE_RST;
      halt_r  <= 1'b0;
      revolution_compare_select_r  <= 1'b0;
    end else if (wr_ctrl) begin
      pmode_r <= reg_wdata[QCEF_PMODE_LSB +: 2];
      rmode_r <= reg_wdata[QCEF_RMODE_LSB +: 2];
      halt_r  <= reg_wdata[QCEF_HALT_BIT];
      revolution_compare_select_r  <= reg_wdata[QCEF_REVOLUTION_COMPARE_SELECT_BIT];
    end
  end

  // Compare registers.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pos_cmp_r <= QCEF_CMP_RST[CNT_W-1:0];
      rev_cmp_r <= QCEF_CMP_RST[CNT_W-1:0];
    end else begin
      if (wr_pcmp) begin
        pos_cmp_r <= wval;
      end
      if (wr_rcmp) begin
        rev_cmp_r <= wval;
      end
    end
  end

  // Interrupt enables; bits 15:14 are not stored at all.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pos_ie_r <= 1'b0;
      por_ie_r <= 1'b0;
      cmb_ie_r <= 1'b0;
      inv_ie_r <= 1'b0;
    end else if (wr_irq) begin
      pos_ie_r <= reg_wdata[QCEF_POS_IE_BIT];
      por_ie_r <= reg_wdata[QCEF_POR_IE_BIT];
      cmb_ie_r <= reg_wdata[QCEF_CMB_IE_BIT];
      inv_ie_r <= reg_wdata[QCEF_INV_IE_BIT];
    end
  end

  // Sticky flags. A zero written clears, a one is ignored, and a set
  // in the same cycle as the clear wins so no event is lost.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pos_f_r <= 1'b0;
      por_f_r <= 1'b0;
      cmb_f_r <= 1'b0;
      inv_f_r <= 1'b0;
    end else begin
      // [R3] Write zero clears.
      pos_f_r <= pos_set
              || (pos_f_r && !(wr_irq && !reg_wdata[QCEF_POS_F_BIT]));
      por_f_r <= por_set
              || (por_f_r && !(wr_irq && !reg_wdata[QCEF_POR_F_BIT]));
      cmb_f_r <= cmb_set
              || (cmb_f_r && !(wr_irq && !reg_wdata[QCEF_CMB_F_BIT]));
      inv_f_r <= inv_set
              || (inv_f_r && !(wr_irq && !reg_wdata[QCEF_INV_F_BIT]));
    end
  end

  // Direction tracking. The last direction is meaningless while the
  // position mode is off, so the known mark drops there.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ovf_dir_r   <= 1'b0;
      last_dir_r  <= 1'b0;
      dir_known_r <= 1'b0;
    end else begin
      // [R16] Capture direction at flow.
      if (flow_pulse) begin
        ovf_dir_r <= step_down;
      end
      // [R17] Latest step direction.
      if (step_pulse && pos_en) begin
        last_dir_r <= step_down;
      end
      // [R20] Forget direction while disabled.
      if (!pos_en) begin
        dir_known_r <= 1'b0;
      end else if (step_pulse) begin
        dir_known_r <= 1'b1;
      end
    end
  end

  // Index before first phase edge after enable.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      no_phase_r <= 1'b0;
      preset_r   <= 1'b0;
      rinh_r     <= 1'b0;
    end else begin
      if (!pos_en || phase_edge) begin
        no_phase_r <= 1'b0;
      end else if (pos_enter) begin
        no_phase_r <= 1'b1;
      end
      // [R18] Early index handling.
      rinh_r   <= index_edge && (no_phase_r || pos_enter) && !phase_edge;
      preset_r <= index_edge && (no_phase_r || pos_enter) && !phase_edge
               && (rmode_r != QCEF_MODE_2);
    end
  end

  // Previous values for change and entry detection.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pmode_prev_r <= QCEF_MODE_RST;
      rmode_prev_r <= QCEF_MODE_RST;
      revolution_compare_select_prev_r  <= 1'b0;
      pos_prev_r   <= '0;
      rev_prev_r   <= '0;
    end else begin
      pmode_prev_r <= pmode_r;
      rmode_prev_r <= rmode_r;
      revolution_compare_select_prev_r  <= revolution_compare_select_r;
      pos_prev_r   <= pos_count;
      rev_prev_r   <= rev_count;
    end
  end

  // Count register write is forwarded to the counter core.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      load_v_r <= 1'b0;
      load_d_r <= '0;
    end else begin
      load_v_r <= wr_cnt;
      if (wr_cnt) begin
        load_d_r <= wval;
      end
    end
  end

  // Read data for the interrupt control register.
  logic [31:0] irq_rd;
  always_comb begin
    irq_rd = 32'h0000_0000;
    // [R4] Flags read as one on read-modify-write.
    irq_rd[QCEF_POS_F_BIT]    = pos_f_r || reg_rmw;
    irq_rd[QCEF_POR_F_BIT]    = por_f_r || reg_rmw;
    irq_rd[QCEF_CMB_F_BIT]    = cmb_f_r || reg_rmw;
    irq_rd[QCEF_INV_F_BIT]    = inv_f_r || reg_rmw;
    irq_rd[QCEF_POS_IE_BIT]   = pos_ie_r;
    irq_rd[QCEF_POR_IE_BIT]   = por_ie_r;
    irq_rd[QCEF_CMB_IE_BIT]   = cmb_ie_r;
    irq_rd[QCEF_INV_IE_BIT]   = inv_ie_r;
    irq_rd[QCEF_OVF_DIR_BIT]  = ovf_dir_r;
    irq_rd[QCEF_LAST_DIR_BIT] = last_dir_r;
    // [R9] Bits 15:14 stay zero from the default above.
  end

  // Registered read data, valid only in the cycle after the strobe.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= 32'h0000_0000;
    end else if (reg_rd) begin
      unique case (reg_addr)
        QCEF_IRQ_CTRL_OFS:  rdata_r <= irq_rd;
        QCEF_CNT_CTRL_OFS:  rdata_r <= {26'h0000000, revolution_compare_select_r, halt_r,
                                        rmode_r, pmode_r};
        QCEF_POS_COUNT_OFS: rdata_r <= 32'(pos_count);
        QCEF_POS_CMP_OFS:   rdata_r <= 32'(pos_cmp_r);
        QCEF_REV_CMP_OFS:   rdata_r <= 32'(rev_cmp_r);
        // Unmapped addresses answer zero.
        default:            rdata_r <= 32'h0000_0000;
      endcase
    end else begin
      rdata_r <= 32'h0000_0000;
    end
  end

  // Interrupt request, a plain level from registered flags.
  // [R1] [R8] [R15] [R21] [R22] Flag and enable pairs.
  assign irq = (pos_f_r && pos_ie_r) || (por_f_r && por_ie_r)
            || (cmb_f_r && cmb_ie_r) || (inv_f_r && inv_ie_r);

  // Outputs toward the bus and the counter core.
  assign reg_rdata                 = rdata_r;
  assign position_mode             = pmode_r;
  assign revolution_count_mode     = rmode_r;
  assign position_halt_bit         = halt_r;
  assign revolution_compare_select = revolution_compare_select_r;
  assign pos_load_valid            = load_v_r;
  assign pos_load_data             = load_d_r;
  assign pos_reset_req             = preset_r;
  assign rev_count_inhibit         = rinh_r;

endmodule : qcef_event_flags

`default_nettype wire

// ---- include/qcef_pkg.sv ----
// Package for the quadrature counter event flag block.
// Holds register offsets, field positions, reset values and mode codes.
// Assumes a 32-bit plain register port with byte addresses.
package qcef_pkg;

  // Register byte offsets on the plain register port.
  localparam logic [7:0] QCEF_IRQ_CTRL_OFS    = 8'h00;
  localparam logic [7:0] QCEF_CNT_CTRL_OFS    = 8'h04;
  localparam logic [7:0] QCEF_POS_COUNT_OFS   = 8'h08;
  localparam logic [7:0] QCEF_POS_CMP_OFS     = 8'h0C;
  localparam logic [7:0] QCEF_REV_CMP_OFS     = 8'h10;

  // Interrupt control register fields, low byte.
  localparam int QCEF_POS_IE_BIT     = 0;
  localparam int QCEF_POS_F_BIT      = 1;
  localparam int QCEF_POR_IE_BIT     = 2;
  localparam int QCEF_POR_F_BIT      = 3;
  // Interrupt control register fields, high byte.
  localparam int QCEF_INV_IE_BIT     = 8;
  localparam int QCEF_INV_F_BIT      = 9;
  localparam int QCEF_LAST_DIR_BIT   = 10;
  localparam int QCEF_OVF_DIR_BIT    = 11;
  localparam int QCEF_CMB_IE_BIT     = 12;
  localparam int QCEF_CMB_F_BIT      = 13;

  // Counter control register fields.
  localparam int QCEF_PMODE_LSB      = 0;
  localparam int QCEF_RMODE_LSB      = 2;
  localparam int QCEF_HALT_BIT       = 4;
  localparam int QCEF_REVOLUTION_COMPARE_SELECT_BIT       = 5;

  // Values after reset.
  localparam logic [1:0]  QCEF_MODE_RST  = 2'h0;
  localparam logic [15:0] QCEF_CMP_RST   = 16'h0000;

  // Position and revolution count modes.
  typedef enum logic [1:0] {
    QCEF_MODE_OFF = 2'b00,
    QCEF_MODE_1   = 2'b01,
    QCEF_MODE_2   = 2'b10,
    QCEF_MODE_3   = 2'b11
  } qcef_mode_type;

endpackage : qcef_pkg

// ---- verification/qcef_event_flags_checker.sv ----
// Concurrent checks on the ports of the event flag block.
// Assumes one clock domain and the register map of qcef_pkg.
`timescale 1ns/10ps
`default_nettype none
module qcef_event_flags_checker
  import qcef_pkg::*;
#(
  parameter int CNT_W = 16
) (
  input wire logic             clk,
  input wire logic             rst_n,
  input wire logic [7:0]       reg_addr,
  input wire logic [31:0]      reg_wdata,
  input wire logic             reg_wr,
  input wire logic             reg_rd,
  input wire logic             reg_rmw,
  input wire logic [31:0]      reg_rdata,
  input wire logic             step_pulse,
  input wire logic             step_down,
  input wire logic             flow_pulse,
  input wire logic             phase_edge,
  input wire logic             index_edge,
  input wire logic [1:0]       position_mode,
  input wire logic [1:0]       revolution_count_mode,
  input wire logic             pos_load_valid,
  input wire logic [CNT_W-1:0] pos_load_data,
  input wire logic             pos_reset_req,
  input wire logic             rev_count_inhibit,
  input wire logic             irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic       rd_irq;   // Plain read of the control register.
  logic       quiet;    // No step or flow pulse and no write in this cycle.
  logic       win_now;  // An index now would come before any phase edge.
  logic       win_r;
  logic [1:0] pmode_r;
  assign rd_irq  = reg_rd && !reg_rmw && reg_addr == QCEF_IRQ_CTRL_OFS;
  assign quiet   = !step_pulse && !flow_pulse && !reg_wr;
  assign win_now = win_r || (pmode_r == 2'b00 && position_mode != 2'b00);
  // Span from leaving mode 00 up to the first phase edge.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pmode_r <= 2'b00;
      win_r   <= 1'b0;
    end else begin
      pmode_r <= position_mode;
      win_r   <= win_now && !phase_edge && position_mode != 2'b00;
    end
  end
  sequence step_read;
    step_pulse && position_mode != 2'b00 ##1 quiet [*2] ##1 rd_irq && quiet;
  endsequence
  sequence flow_read;
    flow_pulse && !step_pulse ##1 quiet [*2] ##1 rd_irq && quiet;
  endsequence
  sequence rev_read;
    step_pulse && step_down && position_mode != 2'b00 ##1 quiet ##1
      step_pulse && !step_down ##1 quiet [*2] ##1 rd_irq && quiet;
  endsequence
  a_rsvd_zero: assert property (
    reg_rd && reg_addr == QCEF_IRQ_CTRL_OFS |=> reg_rdata[15:14] == 2'b00)
    else $error("reserved control bits read as one");
  a_irq_pairs: assert property (
    rd_irq |=> $past(irq) == (reg_rdata[0] & reg_rdata[1] |
      reg_rdata[2] & reg_rdata[3] | reg_rdata[8] & reg_rdata[9] |
      reg_rdata[12] & reg_rdata[13]))
    else $error("irq disagrees with flags and enables");
  a_rmw_ones: assert property (
    reg_rd && reg_rmw && reg_addr == QCEF_IRQ_CTRL_OFS
      |=> reg_rdata[13] && reg_rdata[9] && reg_rdata[3] && reg_rdata[1])
    else $error("flag read as zero in read-modify-write");
  a_load_fwd: assert property (
    reg_wr && reg_addr == QCEF_POS_COUNT_OFS
      |=> pos_load_valid && pos_load_data == $past(reg_wdata[CNT_W-1:0]))
    else $error("count write not forwarded");
  a_early_index: assert property (
    win_now && index_edge && !phase_edge |=> rev_count_inhibit &&
      pos_reset_req == ($past(revolution_count_mode) != 2'b10))
    else $error("early index handled wrongly");
  a_reset_cause: assert property (pos_reset_req |-> $past(index_edge))
    else $error("position reset without index");
  a_last_dir: assert property (step_read |=>
    reg_rdata[QCEF_LAST_DIR_BIT] == $past(step_down, 4))
    else $error("last direction bit wrong");
  a_flow_dir: assert property (flow_read |=>
    reg_rdata[QCEF_OVF_DIR_BIT] == $past(step_down, 4))
    else $error("flow direction bit wrong");
  a_inv_set: assert property (rev_read |=> reg_rdata[QCEF_INV_F_BIT])
    else $error("reversal did not set inversion flag");
endmodule : qcef_event_flags_checker
bind qcef_event_flags qcef_event_flags_checker #(.CNT_W(CNT_W)) u_checker (
  .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rmw(reg_rmw), .reg_rdata(reg_rdata),
  .step_pulse(step_pulse), .step_down(step_down), .flow_pulse(flow_pulse),
  .phase_edge(phase_edge), .index_edge(index_edge),
  .position_mode(position_mode), .pos_load_valid(pos_load_valid),
  .revolution_count_mode(revolution_count_mode), .irq(irq),
  .pos_load_data(pos_load_data), .pos_reset_req(pos_reset_req),
  .rev_count_inhibit(rev_count_inhibit));
`default_nettype wire

// ---- verification/qcef_core_model.sv ----
// Counter core stand-in: position and revolution counts and pulses.
// Assumes the bench calls pulse() and sets rev_count directly.
`timescale 1ns/10ps
`default_nettype none
module qcef_core_model (
  input  wire logic        clk,
  input  wire logic        pos_load_valid,
  input  wire logic [15:0] pos_load_data,
  input  wire logic        pos_reset_req,
  output logic      [15:0] pos_count,
  output logic      [15:0] rev_count,
  output logic             step_pulse,
  output logic             step_down,
  output logic             flow_pulse,
  output logic             phase_edge,
  output logic             index_edge
);
  initial begin
    pos_count = 16'h0000;
    rev_count = 16'h0000;
    {step_pulse, step_down, flow_pulse, phase_edge, index_edge} = 5'h00;
  end
  // One pulse: kind 0 step, 1 flow, 2 index; the count moves with a step.
  task automatic pulse(input int kind, input logic dn);
    @(posedge clk);
    step_down  <= dn;
    step_pulse <= kind == 0;
    phase_edge <= kind == 0;
    flow_pulse <= kind == 1;
    index_edge <= kind == 2;
    if (kind == 0) begin
      pos_count <= dn ? pos_count - 16'h0001
                      : pos_count + 16'h0001;
    end
    @(posedge clk);
    {step_pulse, flow_pulse, phase_edge, index_edge} <= 4'h0;
  endtask : pulse
  always @(posedge clk) begin
    if (pos_reset_req) pos_count <= 16'h0000;
    else if (pos_load_valid) pos_count <= pos_load_data;
  end
endmodule : qcef_core_model
`default_nettype wire

// ---- verification/qcef_event_flags_bench.sv ----
// Self-checking bench for the event flag block and its core model.
// Assumes the register map and bit positions of qcef_pkg.
`timescale 1ns/10ps
`default_nettype none
module qcef_event_flags_bench;
  import qcef_pkg::*;
  logic        clk, rst_n, reg_wr, reg_rd, reg_rmw, irq;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic [15:0] pos_count, rev_count, pos_load_data;
  logic        step_pulse, step_down, flow_pulse, phase_edge, index_edge;
  logic        pos_load_valid, pos_reset_req;
  int          n_mismatch, samples_checked, cycles;
  qcef_event_flags #(.CNT_W(16)) u_qcef_event_flags (
    .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rmw(reg_rmw),
    .reg_rdata(reg_rdata), .pos_count(pos_count), .rev_count(rev_count),
    .step_pulse(step_pulse), .step_down(step_down), .flow_pulse(flow_pulse),
    .phase_edge(phase_edge), .index_edge(index_edge), .position_mode(),
    .revolution_count_mode(), .position_halt_bit(),
    .revolution_compare_select(), .pos_load_valid(pos_load_valid),
    .pos_load_data(pos_load_data), .pos_reset_req(pos_reset_req),
    .rev_count_inhibit(), .irq(irq));
  qcef_core_model u_qcef_core_model (
    .clk(clk), .pos_load_valid(pos_load_valid),
    .pos_load_data(pos_load_data), .pos_reset_req(pos_reset_req),
    .pos_count(pos_count), .rev_count(rev_count), .step_pulse(step_pulse),
    .step_down(step_down), .flow_pulse(flow_pulse),
    .phase_edge(phase_edge), .index_edge(index_edge));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // One-cycle write strobe, released at the edge that takes it.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic m, output logic [31:0] d);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_rmw  <= m;
    reg_addr <= a;
    @(posedge clk);
    reg_rd  <= 1'b0;
    reg_rmw <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    rd(a, 1'b0, d);
    check(d, e);
  endtask : rc
  // Waits one idle cycle so a late flag update has landed, then reads.
  task automatic rb(input int b, input logic e);
    logic [31:0] d;
    @(posedge clk);
    rd(QCEF_IRQ_CTRL_OFS, 1'b0, d);
    check({31'h0, d[b]}, {31'h0, e});
  endtask : rb
  task automatic ci(input logic e);
    @(posedge clk);
    #1 check({31'h0, irq}, {31'h0, e});
  endtask : ci
  task automatic t_regs();
    rc(QCEF_IRQ_CTRL_OFS, 32'h00000000);
    wr(QCEF_IRQ_CTRL_OFS, 32'h00003FFF);
    rc(QCEF_IRQ_CTRL_OFS, 32'h00001105);
    rc(8'h20, 32'h00000000);
    wr(QCEF_IRQ_CTRL_OFS, 32'h00000000);
    $display("test regs done");
  endtask : t_regs
  task automatic t_pos();
    wr(QCEF_CNT_CTRL_OFS, 32'h00000001);
    rb(QCEF_POS_F_BIT, 1'b1);
    wr(QCEF_IRQ_CTRL_OFS, 32'h00000001);
    rb(QCEF_POS_F_BIT, 1'b0);
    wr(QCEF_POS_CMP_OFS, 32'h00000003);
    repeat (3) u_qcef_core_model.pulse(0, 1'b0);
    rb(QCEF_POS_F_BIT, 1'b1);
    ci(1'b1);
    wr(QCEF_IRQ_CTRL_OFS, 32'h00000002);
    ci(1'b0);
    rb(QCEF_POS_F_BIT, 1'b1);
    wr(QCEF_IRQ_CTRL_OFS, 32'h00000000);
    wr(QCEF_POS_CMP_OFS, 32'h00000003);
    rb(QCEF_POS_F_BIT, 1'b1);
    wr(QCEF_CNT_CTRL_OFS, 32'h00000011);
    rc(QCEF_CNT_CTRL_OFS, 32'h00000011);
    wr(QCEF_IRQ_CTRL_OFS, 32'h00000000);
    wr(QCEF_POS_CMP_OFS, 32'h00000009);
    wr(QCEF_POS_COUNT_OFS, 32'h00000009);
    rb(QCEF_POS_F_BIT, 1'b1);
    rc(QCEF_POS_COUNT_OFS, 32'h00000009);
    $display("test position match done");
  endtask : t_pos
  task automatic t_cmb();
    u_qcef_core_model.rev_count <= 16'h0004;
    wr(QCEF_CNT_CTRL_OFS, 32'h00000001);
    wr(QCEF_IRQ_CTRL_OFS, 32'h00000000);
    wr(QCEF_REV_CMP_OFS, 32'h00000004);
    rb(QCEF_CMB_F_BIT, 1'b0);
    wr(QCEF_CNT_CTRL_OFS, 32'h00000005);
    rb(QCEF_CMB_F_BIT, 1'b1);
    wr(QCEF_IRQ_CTRL_OFS, 32'h00001000);
    ci(1'b0);
    wr(QCEF_REV_CMP_OFS, 32'h00000005);
    wr(QCEF_REV_CMP_OFS, 32'h00000004);
    rb(QCEF_CMB_F_BIT, 1'b1);
    ci(1'b1);
    wr(QCEF_CNT_CTRL_OFS, 32'h00000025);
    rc(QCEF_CNT_CTRL_OFS, 32'h00000025);
    wr(QCEF_IRQ_CTRL_OFS, 32'h00000000);
    u_qcef_core_model.pulse(0, 1'b1);
    u_qcef_core_model.pulse(0, 1'b0);
    rb(QCEF_CMB_F_BIT, 1'b1);
    wr(QCEF_IRQ_CTRL_OFS, 32'h00000004);
    ci(1'b0);
    wr(QCEF_POS_CMP_OFS, 32'h00000009);
    rb(QCEF_CMB_F_BIT, 1'b1);
    wr(QCEF_REV_CMP_OFS, 32'h00000005);
    wr(QCEF_REV_CMP_OFS, 32'h00000004);
    ci(1'b1);
    wr(QCEF_IRQ_CTRL_OFS, 32'h00000008);
    ci(1'b0);
    $display("test combined match done");
  endtask : t_cmb
  task automatic t_dir();
    wr(QCEF_CNT_CTRL_OFS, 32'h00000004);
    wr(QCEF_CNT_CTRL_OFS, 32'h00000005);
    rb(QCEF_CMB_F_BIT, 1'b1);
    wr(QCEF_IRQ_CTRL_OFS, 32'h00000100);
    u_qcef_core_model.pulse(0, 1'b1);
    rb(QCEF_INV_F_BIT, 1'b0);
    rb(QCEF_LAST_DIR_BIT, 1'b1);
    ci(1'b0);
    u_qcef_core_model.pulse(0, 1'b0);
    rb(QCEF_INV_F_BIT, 1'b1);
    rb(QCEF_LAST_DIR_BIT, 1'b0);
    ci(1'b1);
    u_qcef_core_model.pulse(1, 1'b1);
    rb(QCEF_OVF_DIR_BIT, 1'b1);
    u_qcef_core_model.pulse(1, 1'b0);
    rb(QCEF_OVF_DIR_BIT, 1'b0);
    $display("test direction done");
  endtask : t_dir
  task automatic t_index();
    logic [31:0] d;
    wr(QCEF_CNT_CTRL_OFS, 32'h00000000);
    wr(QCEF_CNT_CTRL_OFS, 32'h00000001);
    u_qcef_core_model.pulse(2, 1'b0);
    rc(QCEF_POS_COUNT_OFS, 32'h00000000);
    wr(QCEF_CNT_CTRL_OFS, 32'h00000008);
    wr(QCEF_POS_COUNT_OFS, 32'h00000006);
    wr(QCEF_CNT_CTRL_OFS, 32'h00000009);
    u_qcef_core_model.pulse(2, 1'b0);
    rc(QCEF_POS_COUNT_OFS, 32'h00000006);
    rd(QCEF_IRQ_CTRL_OFS, 1'b1, d);
    check(d & 32'h0000220A, 32'h0000220A);
    $display("test index and rmw done");
  endtask : t_index
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : report_and_stop
  // Cuts a hang short well beyond the fewer than two hundred cycles the tests need.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_mismatch++;
      report_and_stop();
    end
  end
  initial begin
    {reg_wr, reg_rd, reg_rmw, rst_n} = 4'h0;
    reg_addr  = 8'h00;
    reg_wdata = 32'h00000000;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_pos();
    t_cmb();
    t_dir();
    t_index();
    report_and_stop();
  end
endmodule : qcef_event_flags_bench
`default_nettype wire
